// ---- src/asd_alternate_space_decoder.sv ----
// Purpose: Attach an address-space tag to each access and decode it to a target
// Assumes: Single clock; request comes from core logic on the same clock
// Notes:   Decode is combinational; route and error outputs are registered once
// Overview of operation
// - Every fetch and normal data access carries an 8-bit tag beside its 32-bit address.
// - The normal tag encodes privilege and fetch versus data.
// - Only privileged alternate accesses supply their own tag, choosing an internal space.
// - Tags 08-0B are user/supervisor instruction and data spaces, all sizes.
// - Tag 02 is control space, all sizes.
// - Tags 03-06 are MMU flush/probe, registers and two TLB diagnostics, single word.
// - Tags 0C-0F are instruction and data cache tags and data, double word.
// - Tags 20-2F are MMU bypass, all sizes.
// - Tags 30/31 store buffer tags/data double; 32 store buffer control single.
// - Single-word store to 36 or 37 flash-clears I or D cache; no loads.
// - Tag 38 is MMU breakpoint diagnostics, double word.
// - Tag 40 is kernel space, single word.
// - Tags 48 and 49 are performance counters A and B, single word.
// - Tags 4A, 4B, 4C are counter breakpoint control, status, action; single word.
// - All other tags, including 4D-FF, have no function.
`timescale 1ns/1ps
`include "asd_consts.svh"
module asd_alternate_space_decoder
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire asd_pkg::asd_req_s req,
   output asd_pkg::asd_target_e   target,
   output logic                   accept,
   output asd_pkg::asd_route_s    route,
   output logic                   icacheClear,
   output logic                   dcacheClear,
   output logic                   accessError
);

   logic [`ASD_TAG_W-1:0]   effTag;
   asd_pkg::asd_sizerule_e  sizeRule;
   logic                    storeOnly;
   logic                    sizeOk;
   logic                    privOk;

   // Normal accesses build their own tag from privilege and kind
   always_comb
   begin
      if (req.alternate && req.supervisor)
         effTag = req.tag;
      else if (req.fetch)
         effTag = req.supervisor ? `ASD_TAG_SUPV_INSN : `ASD_TAG_USER_INSN;
      else
         effTag = req.supervisor ? `ASD_TAG_SUPV_DATA : `ASD_TAG_USER_DATA;
   end

   // Pure table lookup, no state: same-cycle target decode, route follows one cycle later
   always_comb
   begin
      target    = asd_pkg::ASD_NONE;
      sizeRule  = asd_pkg::ASD_SZ_ANY;
      storeOnly = 1'b0;
      if (effTag[7:4] == `ASD_TAG_BYPASS_HI)
         target = asd_pkg::ASD_BYPASS;
      else
      begin
         unique case (effTag)
            `ASD_TAG_CONTROL:    target = asd_pkg::ASD_CONTROL;
            `ASD_TAG_MMU_FLUSH:
            begin
               target   = asd_pkg::ASD_MMU_FLUSH;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_MMU_REGS:
            begin
               target   = asd_pkg::ASD_MMU_REGS;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_CODE_TLB:
            begin
               target   = asd_pkg::ASD_CODE_TLB;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_DATA_TLB:
            begin
               target   = asd_pkg::ASD_DATA_TLB;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_USER_INSN:  target = asd_pkg::ASD_USER_INSN;
            `ASD_TAG_SUPV_INSN:  target = asd_pkg::ASD_SUPV_INSN;
            `ASD_TAG_USER_DATA:  target = asd_pkg::ASD_USER_DATA;
            `ASD_TAG_SUPV_DATA:  target = asd_pkg::ASD_SUPV_DATA;
            `ASD_TAG_ICACHE_TAG:
            begin
               target   = asd_pkg::ASD_ICACHE_TAG;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_ICACHE_DAT:
            begin
               target   = asd_pkg::ASD_ICACHE_DAT;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_DCACHE_TAG:
            begin
               target   = asd_pkg::ASD_DCACHE_TAG;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_DCACHE_DAT:
            begin
               target   = asd_pkg::ASD_DCACHE_DAT;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_SB_TAGS:
            begin
               target   = asd_pkg::ASD_SB_TAGS;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_SB_DATA:
            begin
               target   = asd_pkg::ASD_SB_DATA;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_SB_CTRL:
            begin
               target   = asd_pkg::ASD_SB_CTRL;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_ICLEAR:
            begin
               target    = asd_pkg::ASD_ICLEAR;
               sizeRule  = asd_pkg::ASD_SZ_SINGLE;
               storeOnly = 1'b1;
            end
            `ASD_TAG_DCLEAR:
            begin
               target    = asd_pkg::ASD_DCLEAR;
               sizeRule  = asd_pkg::ASD_SZ_SINGLE;
               storeOnly = 1'b1;
            end
            `ASD_TAG_BKPT_DIAG:
            begin
               target   = asd_pkg::ASD_BKPT_DIAG;
               sizeRule = asd_pkg::ASD_SZ_DOUBLE;
            end
            `ASD_TAG_KERNEL:
            begin
               target   = asd_pkg::ASD_KERNEL;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_PERF_A:
            begin
               target   = asd_pkg::ASD_PERF_A;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_PERF_B:
            begin
               target   = asd_pkg::ASD_PERF_B;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_CBK_CTRL:
            begin
               target   = asd_pkg::ASD_CBK_CTRL;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_CBK_STAT:
            begin
               target   = asd_pkg::ASD_CBK_STAT;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            `ASD_TAG_ACTION:
            begin
               target   = asd_pkg::ASD_ACTION;
               sizeRule = asd_pkg::ASD_SZ_SINGLE;
            end
            default:             target = asd_pkg::ASD_NONE;
         endcase
      end
   end

   always_comb
   begin
      unique case (sizeRule)
         asd_pkg::ASD_SZ_SINGLE: sizeOk = (req.size == `ASD_SIZE_WORD);
         asd_pkg::ASD_SZ_DOUBLE: sizeOk = (req.size == `ASD_SIZE_DOUBLE);
         default:                sizeOk = 1'b1;
      endcase
   end

   // User-mode alternate requests are refused outright
   assign privOk = !req.alternate || req.supervisor;
   assign accept = req.valid && privOk && sizeOk && (target != asd_pkg::ASD_NONE)
                   && (!storeOnly || req.store);

   always_ff @(posedge clk)
   begin
      if (reset)
         route <= '0;
      else
      begin
         route.valid  <= accept;
         route.store  <= req.store;
         route.size   <= req.size;
         route.tag    <= effTag;
         route.addr   <= req.addr;
         route.target <= target;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         icacheClear <= 1'b0;
         dcacheClear <= 1'b0;
      end
      else
      begin
         icacheClear <= accept && (target == asd_pkg::ASD_ICLEAR);
         dcacheClear <= accept && (target == asd_pkg::ASD_DCLEAR);
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         accessError <= 1'b0;
      else
         accessError <= req.valid && !accept;
   end

endmodule

// ---- pkg/asd_consts.svh ----
// Purpose: Tag codes and access sizes for the address-space tag decoder
// Assumes: 8-bit tag, 32-bit address
// Notes:   Definitions only
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH
`define ASD_TAG_W          8
`define ASD_ADDR_W         32
`define ASD_TAG_CONTROL    8'h02
`define ASD_TAG_MMU_FLUSH  8'h03
`define ASD_TAG_MMU_REGS   8'h04
`define ASD_TAG_CODE_TLB   8'h05
`define ASD_TAG_DATA_TLB   8'h06
`define ASD_TAG_USER_INSN  8'h08
`define ASD_TAG_SUPV_INSN  8'h09
`define ASD_TAG_USER_DATA  8'h0A
`define ASD_TAG_SUPV_DATA  8'h0B
`define ASD_TAG_ICACHE_TAG 8'h0C
`define ASD_TAG_ICACHE_DAT 8'h0D
`define ASD_TAG_DCACHE_TAG 8'h0E
`define ASD_TAG_DCACHE_DAT 8'h0F
`define ASD_TAG_BYPASS_HI  4'h2
`define ASD_TAG_SB_TAGS    8'h30
`define ASD_TAG_SB_DATA    8'h31
`define ASD_TAG_SB_CTRL    8'h32
`define ASD_TAG_ICLEAR     8'h36
`define ASD_TAG_DCLEAR     8'h37
`define ASD_TAG_BKPT_DIAG  8'h38
`define ASD_TAG_KERNEL     8'h40
`define ASD_TAG_PERF_A     8'h48
`define ASD_TAG_PERF_B     8'h49
`define ASD_TAG_CBK_CTRL   8'h4A
`define ASD_TAG_CBK_STAT   8'h4B
`define ASD_TAG_ACTION     8'h4C
`define ASD_SIZE_BYTE      2'h0
`define ASD_SIZE_HALF      2'h1
`define ASD_SIZE_WORD      2'h2
`define ASD_SIZE_DOUBLE    2'h3
`endif

// ---- pkg/asd_pkg.sv ----
// Purpose: Types for the address-space tag decoder
// Assumes: Constants from asd_consts.svh
// Notes:   Target list is one-hot-free enum
`include "asd_consts.svh"
package asd_pkg;
   typedef enum logic [4:0] {
      ASD_NONE, ASD_CONTROL, ASD_MMU_FLUSH, ASD_MMU_REGS, ASD_CODE_TLB, ASD_DATA_TLB,
      ASD_USER_INSN, ASD_SUPV_INSN, ASD_USER_DATA, ASD_SUPV_DATA,
      ASD_ICACHE_TAG, ASD_ICACHE_DAT, ASD_DCACHE_TAG, ASD_DCACHE_DAT, ASD_BYPASS,
      ASD_SB_TAGS, ASD_SB_DATA, ASD_SB_CTRL, ASD_ICLEAR, ASD_DCLEAR, ASD_BKPT_DIAG,
      ASD_KERNEL, ASD_PERF_A, ASD_PERF_B, ASD_CBK_CTRL, ASD_CBK_STAT, ASD_ACTION
   } asd_target_e;

   typedef enum logic [1:0] {ASD_SZ_ANY, ASD_SZ_SINGLE, ASD_SZ_DOUBLE} asd_sizerule_e;

   // Request from the core pipeline
   typedef struct packed {
      logic                     valid;
      logic                     alternate;
      logic                     fetch;
      logic                     supervisor;
      logic                     store;
      logic [1:0]               size;
      logic [`ASD_TAG_W-1:0]    tag;
      logic [`ASD_ADDR_W-1:0]   addr;
   } asd_req_s;

   // Routed access toward memory and internal targets
   typedef struct packed {
      logic                     valid;
      logic                     store;
      logic [1:0]               size;
      logic [`ASD_TAG_W-1:0]    tag;
      logic [`ASD_ADDR_W-1:0]   addr;
      asd_target_e              target;
   } asd_route_s;
endpackage

// ---- testbench/asd_decoder_monitor.sv ----
// Purpose: Port-level assertions for the tag decoder
// Assumes: Single clock, synchronous reset
// Notes:   Bound to the decoder top
`timescale 1ns/1ps
`include "asd_consts.svh"
module asd_decoder_monitor
(
   input wire logic                 clk,
   input wire logic                 reset,
   input wire asd_pkg::asd_req_s    req,
   input wire asd_pkg::asd_target_e target,
   input wire logic                 accept,
   input wire asd_pkg::asd_route_s  route,
   input wire logic                 icacheClear,
   input wire logic                 dcacheClear,
   input wire logic                 accessError
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   logic altSup;
   assign altSup = req.valid && req.alternate && req.supervisor;
   a_route_on_accept: assert property (accept |=> route.valid && route.target == $past(target))
      else $error("route missing after accept");
   a_error_on_refuse: assert property (req.valid && !accept |=> accessError && !route.valid)
      else $error("refused access without error");
   a_icache_clear: assert property (accept && target == asd_pkg::ASD_ICLEAR |=> icacheClear)
      else $error("icache clear missing");
   a_dcache_clear: assert property (accept && target == asd_pkg::ASD_DCLEAR |=> dcacheClear)
      else $error("dcache clear missing");
   a_clear_load_refused: assert property (altSup && !req.store && req.tag[7:1] == 7'h1B |-> !accept)
      else $error("load to clear space accepted");
   a_user_alt_refused: assert property (req.valid && req.alternate && !req.supervisor |-> !accept)
      else $error("user alternate accepted");
   a_normal_tag: assert property (req.valid && !req.alternate
      |=> route.tag == {6'h02, !$past(req.fetch), $past(req.supervisor)}) else $error("normal tag wrong");
   a_unassigned_none: assert property (altSup && req.tag >= 8'h4D |-> target == asd_pkg::ASD_NONE && !accept)
      else $error("unassigned tag decoded");
   c_icache: cover property (icacheClear);
   c_error: cover property (accessError);
   c_bypass: cover property (route.valid && route.target == asd_pkg::ASD_BYPASS);
endmodule
bind asd_alternate_space_decoder asd_decoder_monitor mon (.clk(clk), .reset(reset), .req(req), .target(target),
   .accept(accept), .route(route), .icacheClear(icacheClear), .dcacheClear(dcacheClear), .accessError(accessError));

// ---- testbench/asd_core_model.sv ----
// Purpose: Core pipeline stand-in driving requests
// Assumes: Bench sets cmd at the falling edge
// Notes:   Idle cycles scramble fields
`timescale 1ns/1ps
module asd_core_model
(
   input  wire asd_pkg::asd_req_s cmd,
   output asd_pkg::asd_req_s      req
);
   // Inverted stale fields, so a decoder that ignores valid is caught
   assign req = cmd.valid ? cmd : {1'b0, ~cmd[$bits(cmd)-2:0]};
endmodule

// ---- testbench/alternate_space_decoder_bench.sv ----
// Purpose: Self-checking bench for the tag decoder
// Assumes: 25 MHz clock, synchronous reset
// Notes:   Table rows first, awkward cases after
`timescale 1ns/1ps
module alternate_space_decoder_bench;
   typedef struct packed {logic alt, fetch, sup, st; logic [1:0] sz; logic [7:0] tg;
      asd_pkg::asd_target_e tgt; logic acc;} asd_row_s;
   logic                 clk = 0;
   logic                 reset = 1;
   asd_pkg::asd_req_s    cmd = '0;
   asd_pkg::asd_req_s    req;
   asd_pkg::asd_target_e target;
   asd_pkg::asd_route_s  route;
   logic                 accept, icacheClear, dcacheClear, accessError;
   int                   errors = 0;
   int                   comparisons = 0;
   asd_row_s rows [33] = '{
      '{0,1,0,0,0,8'hFF,asd_pkg::ASD_USER_INSN,1}, '{0,1,1,0,3,8'h36,asd_pkg::ASD_SUPV_INSN,1},
      '{0,0,0,1,1,8'h00,asd_pkg::ASD_USER_DATA,1}, '{0,0,1,1,2,8'h4D,asd_pkg::ASD_SUPV_DATA,1},
      '{1,0,1,1,0,8'h02,asd_pkg::ASD_CONTROL,1}, '{1,0,1,0,2,8'h03,asd_pkg::ASD_MMU_FLUSH,1},
      '{1,0,1,1,3,8'h04,asd_pkg::ASD_MMU_REGS,0}, '{1,0,1,0,2,8'h05,asd_pkg::ASD_CODE_TLB,1},
      '{1,0,1,1,2,8'h06,asd_pkg::ASD_DATA_TLB,1}, '{1,0,1,0,3,8'h0C,asd_pkg::ASD_ICACHE_TAG,1},
      '{1,0,1,1,2,8'h0F,asd_pkg::ASD_DCACHE_DAT,0}, '{1,0,1,0,0,8'h20,asd_pkg::ASD_BYPASS,1},
      '{1,0,1,1,3,8'h2F,asd_pkg::ASD_BYPASS,1}, '{1,0,1,1,3,8'h31,asd_pkg::ASD_SB_DATA,1},
      '{1,0,1,0,3,8'h32,asd_pkg::ASD_SB_CTRL,0}, '{1,0,1,1,2,8'h36,asd_pkg::ASD_ICLEAR,1},
      '{1,0,1,0,2,8'h37,asd_pkg::ASD_DCLEAR,0}, '{1,0,1,1,2,8'h37,asd_pkg::ASD_DCLEAR,1},
      '{1,0,1,0,3,8'h38,asd_pkg::ASD_BKPT_DIAG,1}, '{1,0,1,1,2,8'h40,asd_pkg::ASD_KERNEL,1},
      '{1,0,1,0,2,8'h49,asd_pkg::ASD_PERF_B,1}, '{1,0,1,1,2,8'h4C,asd_pkg::ASD_ACTION,1},
      '{1,0,1,0,2,8'h07,asd_pkg::ASD_NONE,0}, '{1,0,1,1,2,8'h39,asd_pkg::ASD_NONE,0},
      '{1,0,1,0,0,8'h1F,asd_pkg::ASD_NONE,0}, '{1,0,1,1,3,8'h0D,asd_pkg::ASD_ICACHE_DAT,1},
      '{1,0,1,0,3,8'h0E,asd_pkg::ASD_DCACHE_TAG,1}, '{1,0,1,1,3,8'h30,asd_pkg::ASD_SB_TAGS,1},
      '{1,0,1,0,2,8'h48,asd_pkg::ASD_PERF_A,1}, '{1,0,1,1,2,8'h4A,asd_pkg::ASD_CBK_CTRL,1},
      '{1,0,1,0,2,8'h4B,asd_pkg::ASD_CBK_STAT,1}, '{1,0,1,1,1,8'h41,asd_pkg::ASD_NONE,0},
      '{1,0,1,0,3,8'hFF,asd_pkg::ASD_NONE,0}};
   asd_core_model model (.cmd(cmd), .req(req));
   asd_alternate_space_decoder dut (.clk(clk), .reset(reset), .req(req), .target(target), .accept(accept),
      .route(route), .icacheClear(icacheClear), .dcacheClear(dcacheClear), .accessError(accessError));
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want)
      begin
         errors++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic issue(input logic [41:0] r);
      @(negedge clk);
      cmd <= {1'b1, r[41:36], r[35:28], 32'hA5C3_0F18};
   endtask
   task automatic run_row(input asd_row_s r);
      logic [7:0] expTag;
      // Normal accesses carry the built-in tag, alternate ones their own
      expTag = r.alt ? r.tg : {6'h02, !r.fetch, r.sup};
      issue({r.alt, r.fetch, r.sup, r.st, r.sz, r.tg, 28'h0});
      #5;
      check(target, r.tgt);
      check(accept, r.acc);
      @(posedge clk);
      #1;
      check({route.valid, accessError}, {r.acc, !r.acc});
      check(icacheClear, r.acc && r.tgt == asd_pkg::ASD_ICLEAR);
      check(dcacheClear, r.acc && r.tgt == asd_pkg::ASD_DCLEAR);
      check({route.target, route.tag}, {r.tgt, expTag});
      check({route.store, route.size, route.addr}, {r.st, r.sz, 32'hA5C3_0F18});
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   initial
   begin
      // Generous bound: about forty-five cycles of work
      #20000;
      errors++;
      end_of_test;
   end
   initial
   begin
      repeat (6) @(negedge clk);
      check({route, icacheClear, dcacheClear, accessError}, '0);
      reset <= 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      issue({1'b1, 1'b0, 1'b0, 1'b1, 2'h2, 8'h36, 28'h0});
      @(posedge clk);
      #1;
      check({accessError, icacheClear, accept}, 3'b100);
      @(negedge clk);
      cmd.valid <= 1'b0;
      @(posedge clk);
      #1;
      check({route.valid, accessError}, 2'b00);
      issue({1'b1, 1'b0, 1'b1, 1'b1, 2'h2, 8'h37, 28'h0});
      reset <= 1'b1;
      @(posedge clk);
      #1;
      check({route, icacheClear, dcacheClear, accessError}, '0);
      @(negedge clk);
      reset <= 1'b0;
      cmd.valid <= 1'b0;
      run_row(rows[17]);
      end_of_test;
   end
endmodule
